// File: shared/intc_pkg.sv
package intc_pkg;

  localparam int NUM_BANKS = 3;
  localparam int BANK_INPUTS = 8;

  localparam logic [7:0] BANK_A_BASE = 8'h30;
  localparam logic [7:0] BANK_B_BASE = 8'h20;
  localparam logic [7:0] BANK_C_BASE = 8'ha0;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h01;
  localparam logic [7:0] OFS_COMPAT_RD = 8'h02;
  localparam logic [7:0] OFS_VECTOR = 8'h08;
  localparam logic [7:0] VECTOR_SPAN_MASK = 8'hf8;

  // First init word fields
  localparam int INIT1_SEL_BIT = 4;
  localparam int INIT1_LEVEL_BIT = 3;
  localparam int INIT1_SINGLE_BIT = 1;
  localparam int INIT1_NEED_W4_BIT = 0;
  // Operation word discriminator and fields, word 4 fields, poll valid bit
  localparam int OP_CMD3_BIT = 3;
  localparam int OP2_ROTATE_BIT = 7;
  localparam int OP2_SPECIFIC_BIT = 6;
  localparam int OP2_EOI_BIT = 5;
  localparam int OP3_SPMASK_ENABLE_BIT = 6;
  localparam int OP3_SPMASK_SELECT_BIT = 5;
  localparam int OP3_POLL_BIT = 2;
  localparam int OP3_READ_REG_BIT = 1;
  localparam int OP3_READ_SVC_BIT = 0;
  localparam int W4_AUTO_EOI_BIT = 1;
  localparam int W4_NESTED_BIT = 4;
  localparam int POLL_VALID_BIT = 7;

  localparam logic [2:0] COMPAT_LEVEL = 3'h2;
  localparam logic [2:0] LOWEST_AFTER_INIT = 3'h7;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] VECTOR_RESET = 8'h00;
  localparam logic [7:0] WORD_RESET = 8'h00;
  localparam logic [7:0] PINS_IDLE = 8'hff;

  typedef enum logic [2:0] {
    ST_UNINIT,
    ST_COMPAT,
    ST_CASCADE,
    ST_WORD4,
    ST_READY
  } init_state_e;

  function automatic logic [7:0] bank_base(input int b);
    if (b == 0)
      return BANK_A_BASE;
    else if (b == 1)
      return BANK_B_BASE;
    else
      return BANK_C_BASE;
  endfunction : bank_base

endpackage : intc_pkg

// File: rtl/intc_banks.sv
`timescale 1ns/100ps
`default_nettype none

module intc_banks
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic [23:0] irq_n,
  input wire logic ack_req,
  output logic ack_valid,
  output logic [7:0] ack_vector,
  output logic int_out
);

  localparam int NB = intc_pkg::NUM_BANKS;
  localparam int NI = intc_pkg::BANK_INPUTS;

  // Highest-priority set bit given the current lowest-priority level
  function automatic logic [3:0] prio_pick(input logic [7:0] req, input logic [2:0] low);
    logic [2:0] lvl;
    logic [3:0] res;
    res = 4'h0;
    for (int k = 8; k >= 1; k--)
    begin
      lvl = low + 3'(k);
      if (req[lvl])
        res = {1'b1, lvl};
    end
    return res;
  endfunction : prio_pick

  // Zero is the highest priority
  function automatic logic [2:0] prio_rank(input logic [2:0] lvl, input logic [2:0] low);
    return 3'(lvl - low - 3'h1);
  endfunction : prio_rank

  // Pin synchroniser: three stages, accepted when stages two and three agree
  logic [23:0] sync1;
  logic [23:0] sync2;
  logic [23:0] sync3;
  logic [23:0] pins_filt;
  wire [23:0] agree = ~(sync2 ^ sync3);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1 <= {3{intc_pkg::PINS_IDLE}};
      sync2 <= {3{intc_pkg::PINS_IDLE}};
      sync3 <= {3{intc_pkg::PINS_IDLE}};
      pins_filt <= {3{intc_pkg::PINS_IDLE}};
    end
    else
    begin
      sync1 <= irq_n;
      sync2 <= sync1;
      sync3 <= sync2;
      pins_filt <= (agree & sync2) | (~agree & pins_filt);
    end
  end

  logic [NB-1:0] want;
  logic [NB-1:0] grant;
  logic [NB-1:0] compat_flag;
  logic [NB-1:0] rd_hit;
  logic [7:0] rd_val [NB];
  logic [7:0] pick_vec [NB];

  // Shared compat level: any bank's flag holds it up
  wire compat_any = |compat_flag;

  // Acknowledge goes to the first bank with a serviceable request
  assign grant[0] = ack_req & want[0];
  assign grant[1] = ack_req & want[1] & ~want[0];
  assign grant[2] = ack_req & want[2] & ~want[1] & ~want[0];

  for (genvar b = 0; b < NB; b++)
  begin : bank
    localparam logic [7:0] BASE = intc_pkg::bank_base(b);
    localparam logic [7:0] ADDR_CMD = BASE | intc_pkg::OFS_CMD;
    localparam logic [7:0] ADDR_DATA = BASE | intc_pkg::OFS_DATA;
    localparam logic [7:0] ADDR_COMPAT = BASE | intc_pkg::OFS_COMPAT_RD;
    localparam logic [7:0] ADDR_VEC = BASE | intc_pkg::OFS_VECTOR;

    intc_pkg::init_state_e st;
    logic [7:0] mask;
    logic [7:0] pend;
    logic [7:0] svc;
    logic [7:0] prev_act;
    logic [7:0] vec [NI];
    logic [7:0] compat_word;
    logic [7:0] cascade_word;
    logic [2:0] lowest;
    logic level_mode;
    logic cascade;
    logic need_w4;
    logic auto_eoi;
    logic nested;
    logic rot_auto_eoi;
    logic spmask;
    logic read_svc;
    logic poll_armed;
    logic cflag;

    // Address decoding
    wire hit_cmd = bus_addr == ADDR_CMD;
    wire hit_data = bus_addr == ADDR_DATA;
    wire hit_compat = bus_addr == ADDR_COMPAT;
    wire hit_vec = (bus_addr & intc_pkg::VECTOR_SPAN_MASK) == ADDR_VEC;
    wire [2:0] vec_idx = bus_addr[2:0];
    wire ready = st == intc_pkg::ST_READY;

    wire w_init1 = bus_wr & hit_cmd & bus_wdata[intc_pkg::INIT1_SEL_BIT];
    // operation words any time once ready
    wire w_op2 = bus_wr & hit_cmd & ready & ~bus_wdata[intc_pkg::INIT1_SEL_BIT]
      & ~bus_wdata[intc_pkg::OP_CMD3_BIT];
    wire w_op3 = bus_wr & hit_cmd & ready & ~bus_wdata[intc_pkg::INIT1_SEL_BIT]
      & bus_wdata[intc_pkg::OP_CMD3_BIT];
    wire w_data = bus_wr & hit_data;
    wire w_vec = bus_wr & hit_vec;
    wire r_status = bus_rd & hit_cmd;
    wire r_compat = bus_rd & hit_compat;

    // pins inverted; in bank A only, compat request replaces the level 2 pin
    wire [7:0] pin_act = ~pins_filt[b*8 +: 8];
    wire [7:0] act;
    if (b == 0)
    begin : with_compat
      assign act = (pin_act & ~(8'h01 << intc_pkg::COMPAT_LEVEL))
        | ({7'h00, compat_any} << intc_pkg::COMPAT_LEVEL);
    end
    else
    begin : plain
      assign act = pin_act;
    end

    wire [7:0] rise = act & ~prev_act;

    // fully nested unless special mask mode drops the nesting test
    wire [7:0] cand = pend & ~mask & (spmask ? ~svc : 8'hff);
    wire [3:0] pick = prio_pick(cand, lowest);
    wire [3:0] top_svc = prio_pick(svc, lowest);
    wire beats = ~top_svc[3] | (prio_rank(pick[2:0], lowest) < prio_rank(top_svc[2:0], lowest));
    wire serve = ready & pick[3] & (spmask | beats);

    // status read after poll acts as acknowledge
    wire poll_take = r_status & poll_armed & serve;
    wire take = poll_take | grant[b];
    wire [7:0] take_bit = take ? (8'h01 << pick[2:0]) : 8'h00;

    // EOI level comes from the word or from top in-service bit
    wire op2_eoi = bus_wdata[intc_pkg::OP2_EOI_BIT];
    wire op2_spec = bus_wdata[intc_pkg::OP2_SPECIFIC_BIT];
    wire op2_rot = bus_wdata[intc_pkg::OP2_ROTATE_BIT];
    wire [2:0] op2_lvl = bus_wdata[2:0];
    wire eoi_do = w_op2 & op2_eoi & (op2_spec | top_svc[3]);
    wire [2:0] eoi_lvl = op2_spec ? op2_lvl : top_svc[2:0];
    wire [7:0] eoi_bit = eoi_do ? (8'h01 << eoi_lvl) : 8'h00;

    wire [7:0] next_svc = (svc & ~eoi_bit) | (auto_eoi ? 8'h00 : take_bit);
    // Set wins over acknowledge clear in edge mode
    wire [7:0] next_pend = level_mode ? act : ((pend & ~take_bit) | rise);
    wire [7:0] poll_code = serve ? {1'b1, 4'h0, pick[2:0]} : 8'h00;

    assign want[b] = serve;
    assign compat_flag[b] = cflag;
    assign pick_vec[b] = vec[pick[2:0]];
    assign rd_hit[b] = hit_cmd | hit_data | hit_compat | hit_vec;
    assign rd_val[b] = hit_cmd ? (poll_armed ? poll_code : (read_svc ? svc : pend))
      : hit_data ? mask
      : hit_compat ? compat_word
      : hit_vec ? vec[vec_idx]
      : 8'h00;

    // sequence of init words; restart via first word
    always_ff @(posedge clk)
    begin
      if (sys_rst)
        st <= intc_pkg::ST_UNINIT;
      else if (w_init1)
        st <= intc_pkg::ST_COMPAT;
      else if (w_data)
      begin
        case (st)
          intc_pkg::ST_COMPAT:
            st <= cascade ? intc_pkg::ST_CASCADE
              : (need_w4 ? intc_pkg::ST_WORD4 : intc_pkg::ST_READY);
          intc_pkg::ST_CASCADE:
            st <= need_w4 ? intc_pkg::ST_WORD4 : intc_pkg::ST_READY;
          intc_pkg::ST_WORD4:
            st <= intc_pkg::ST_READY;
          default:
            st <= st;
        endcase
      end
    end

    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        level_mode <= 1'b0;
        cascade <= 1'b0;
        need_w4 <= 1'b0;
      end
      else if (w_init1)
      begin
        level_mode <= bus_wdata[intc_pkg::INIT1_LEVEL_BIT];
        cascade <= ~bus_wdata[intc_pkg::INIT1_SINGLE_BIT];
        need_w4 <= bus_wdata[intc_pkg::INIT1_NEED_W4_BIT];
      end
    end

    // Data port: init words in sequence, mask word when ready
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        mask <= intc_pkg::MASK_RESET;
        compat_word <= intc_pkg::WORD_RESET;
        cascade_word <= intc_pkg::WORD_RESET;
        auto_eoi <= 1'b0;
        nested <= 1'b0;
      end
      // mask cleared; no auto EOI without word 4
      else if (w_init1)
      begin
        mask <= 8'h00;
        auto_eoi <= 1'b0;
        nested <= 1'b0;
      end
      else if (w_data)
      begin
        if (st == intc_pkg::ST_COMPAT)
          compat_word <= bus_wdata;
        else if (st == intc_pkg::ST_CASCADE)
          cascade_word <= bus_wdata;
        // word 4 only in its slot
        else if (st == intc_pkg::ST_WORD4)
        begin
          auto_eoi <= bus_wdata[intc_pkg::W4_AUTO_EOI_BIT];
          nested <= bus_wdata[intc_pkg::W4_NESTED_BIT];
        end
        else if (ready)
          mask <= bus_wdata;
      end
    end

    // compat word write raises the shared request
    // read clears it; a same-cycle write still wins
    wire compat_set = w_data & (st == intc_pkg::ST_COMPAT);

    always_ff @(posedge clk)
    begin
      if (sys_rst)
        cflag <= 1'b0;
      else
        cflag <= compat_set | (cflag & ~r_compat);
    end

    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        spmask <= 1'b0;
        read_svc <= 1'b0;
        poll_armed <= 1'b0;
      end
      else if (w_init1)
      begin
        spmask <= 1'b0;
        read_svc <= 1'b0;
        poll_armed <= 1'b0;
      end
      else if (w_op3)
      begin
        // select bit counts only when enabled
        if (bus_wdata[intc_pkg::OP3_SPMASK_ENABLE_BIT])
          spmask <= bus_wdata[intc_pkg::OP3_SPMASK_SELECT_BIT];
        // Poll overrides a read-register request
        poll_armed <= bus_wdata[intc_pkg::OP3_POLL_BIT];
        if (~bus_wdata[intc_pkg::OP3_POLL_BIT] & bus_wdata[intc_pkg::OP3_READ_REG_BIT])
          read_svc <= bus_wdata[intc_pkg::OP3_READ_SVC_BIT];
      end
      // poll lasts one status read, selection persists
      else if (r_status)
        poll_armed <= 1'b0;
    end

    // Priority rotation and automatic-EOI rotation mode
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        lowest <= intc_pkg::LOWEST_AFTER_INIT;
        rot_auto_eoi <= 1'b0;
      end
      // input seven lowest after first word
      else if (w_init1)
      begin
        lowest <= intc_pkg::LOWEST_AFTER_INIT;
        rot_auto_eoi <= 1'b0;
      end
      else if (w_op2)
      begin
        if (op2_rot & op2_eoi & eoi_do)
          lowest <= eoi_lvl;
        else if (op2_rot & op2_spec & ~op2_eoi)
          lowest <= op2_lvl;
        else if (~op2_spec & ~op2_eoi)
          rot_auto_eoi <= op2_rot;
      end
      else if (take & auto_eoi & rot_auto_eoi)
        lowest <= pick[2:0];
    end

    // Pending and in-service registers
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        pend <= 8'h00;
        svc <= 8'h00;
        prev_act <= 8'hff;
      end
      // in edge mode an input must deassert then assert again
      else if (w_init1)
      begin
        pend <= 8'h00;
        prev_act <= 8'hff;
      end
      else
      begin
        pend <= next_pend;
        svc <= next_svc;
        prev_act <= act;
      end
    end

    always_ff @(posedge clk)
    begin
      if (sys_rst)
        vec <= '{default: intc_pkg::VECTOR_RESET};
      else if (w_vec)
        vec[vec_idx] <= bus_wdata;
    end
  end

  // Read data: held between reads, unmapped addresses return zero
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    for (int b = 0; b < NB; b++)
      if (rd_hit[b])
        rd_mux = rd_val[b];
  end

  wire [7:0] ack_mux = grant[0] ? pick_vec[0] : (grant[1] ? pick_vec[1] : pick_vec[2]);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bus_rdata <= 8'h00;
      ack_valid <= 1'b0;
      ack_vector <= 8'h00;
      int_out <= 1'b0;
    end
    else
    begin
      if (bus_rd)
        bus_rdata <= rd_mux;
      ack_valid <= |grant;
      if (|grant)
        ack_vector <= ack_mux;
      int_out <= |want;
    end
  end

endmodule : intc_banks

`default_nettype wire

// File: bench/intc_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module intc_monitor
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic ack_req,
  input wire logic ack_valid,
  input wire logic [7:0] ack_vector,
  input wire logic int_out
);
  logic poll_armed;
  logic any_init;
  wire logic hi_ok = bus_addr[7:4] == 4'h2 || bus_addr[7:4] == 4'h3 || bus_addr[7:4] == 4'ha;
  wire logic lo_ok = bus_addr[3] || bus_addr[2:0] <= 3'h2;
  wire logic poll_wr = bus_wr && bus_addr == intc_pkg::BANK_A_BASE && bus_wdata[4:2] == 3'h3;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Poll tracked for bank A only
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      poll_armed <= 1'h0;
      any_init <= 1'h0;
    end
    else
    begin
      if (poll_wr)
        poll_armed <= 1'h1;
      else if (bus_rd && bus_addr == intc_pkg::BANK_A_BASE)
        poll_armed <= 1'h0;
      if (bus_wr && bus_addr[3:0] == 4'h0 && bus_wdata[4] && hi_ok)
        any_init <= 1'h1;
    end
  end

  sequence status_rd;
    bus_rd && bus_addr == intc_pkg::BANK_A_BASE;
  endsequence

  sequence vec_wr;
    bus_wr && bus_addr[3] && hi_ok;
  endsequence

  reset_clears_a: assert property ($past(sys_rst) |-> bus_rdata == 8'h00 && !int_out)
    else $error("outputs not idle after reset");
  int_quiet_a: assert property (!any_init |-> !int_out)
    else $error("request signalled before initialisation");
  ack_cause_a: assert property (ack_valid |-> $past(ack_req))
    else $error("acknowledge answer without request");
  vector_hold_a: assert property ($changed(ack_vector) |-> ack_valid)
    else $error("vector changed outside acknowledge");
  vec_readback_a: assert property ((vec_wr ##2 bus_rd && bus_addr == $past(bus_addr, 2))
    |=> bus_rdata == $past(bus_wdata, 3))
    else $error("vector register readback wrong");
  rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data changed without a read");
  unmapped_read_a: assert property (bus_rd && !(hi_ok && lo_ok) |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  poll_format_a: assert property ((poll_armed and status_rd)
    |=> bus_rdata[6:3] == 4'h0 && (bus_rdata[7] || bus_rdata[2:0] == 3'h0))
    else $error("poll result malformed");
endmodule : intc_monitor

bind intc_banks intc_monitor intc_monitor_inst (.clk(clk), .sys_rst(sys_rst),
  .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata), .ack_req(ack_req), .ack_valid(ack_valid),
  .ack_vector(ack_vector), .int_out(int_out));

`default_nettype wire

// File: bench/host_model.sv
`timescale 1ns/100ps
`default_nettype none

module host_model
(
  input wire logic clk,
  output logic [7:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  output logic ack_req,
  input wire logic ack_valid,
  input wire logic [7:0] ack_vector
);
  initial
  begin
    bus_addr = 8'h00;
    bus_wr = 1'h0;
    bus_rd = 1'h0;
    bus_wdata = 8'h00;
    ack_req = 1'h0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'h1;
    @(posedge clk);
    bus_wr <= 1'h0;
    // Released lines never keep the last value
    bus_addr <= ~a;
    bus_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'h1;
    @(posedge clk);
    bus_rd <= 1'h0;
    bus_addr <= ~a;
    #1;
    d = bus_rdata;
  endtask : rd

  task automatic ack(output logic v, output logic [7:0] vec);
    @(posedge clk);
    ack_req <= 1'h1;
    @(posedge clk);
    ack_req <= 1'h0;
    #1;
    v = ack_valid;
    vec = ack_vector;
  endtask : ack

  task automatic init(input logic [7:0] b, input logic [7:0] w1, input logic [7:0] w4);
    wr(b, w1);
    wr(b + 8'h01, 8'h5a);
    if (!w1[1])
      wr(b + 8'h01, 8'h04);
    if (w1[0])
      wr(b + 8'h01, w4);
  endtask : init

  task automatic clear_compat();
    logic [7:0] d;
    for (int b = 0; b < 3; b++)
      rd(intc_pkg::bank_base(b) + intc_pkg::OFS_COMPAT_RD, d);
  endtask : clear_compat
endmodule : host_model

`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  localparam logic [7:0] ba = intc_pkg::BANK_A_BASE;
  localparam logic [7:0] bb = intc_pkg::BANK_B_BASE;
  localparam logic [7:0] bc = intc_pkg::BANK_C_BASE;
  logic clk;
  logic sys_rst;
  logic [23:0] irq_n;
  logic [7:0] bus_addr;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  logic ack_req;
  logic ack_valid;
  logic [7:0] ack_vector;
  logic int_out;
  logic v;
  logic [7:0] vec;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;

  intc_banks intc_banks_inst (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .irq_n(irq_n), .ack_req(ack_req), .ack_valid(ack_valid), .ack_vector(ack_vector),
    .int_out(int_out));

  host_model host_model_inst (.clk(clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .ack_req(ack_req),
    .ack_valid(ack_valid), .ack_vector(ack_vector));

  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // Bounds a hang well above the run length
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string name);
    logic [7:0] d;
    host_model_inst.rd(a, d);
    check(name, d, exp);
  endtask : rc

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host_model_inst.wr(a, d);
  endtask : w

  // Fresh falling edge, past the pin synchronisers
  task automatic raise(input int i);
    @(posedge clk);
    irq_n[i] <= 1'h1;
    repeat (6) @(posedge clk);
    irq_n[i] <= 1'h0;
    repeat (6) @(posedge clk);
  endtask : raise

  initial
  begin
    sys_rst = 1'h1;
    irq_n = 24'hffffff;
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    rc(8'h40, 8'h00, "unmapped");
    check("int idle", {7'h00, int_out}, 8'h00);
    $display("test reset done");
    host_model_inst.init(ba, 8'h11, 8'h00);
    repeat (6) @(posedge clk);
    rc(ba, 8'h04, "pending A compat");
    rc(ba + 8'h01, 8'h00, "mask A");
    check("int raised", {7'h00, int_out}, 8'h01);
    w(ba, 8'h0c);
    rc(ba, 8'h82, "poll A");
    w(ba, 8'h0b);
    rc(ba, 8'h04, "in service A");
    rc(ba, 8'h04, "in service A again");
    w(ba, 8'h20);
    rc(ba, 8'h00, "in service after eoi");
    rc(ba + 8'h02, 8'h5a, "compat A");
    repeat (3) @(posedge clk);
    check("int cleared", {7'h00, int_out}, 8'h00);
    $display("test init A done");
    w(ba + 8'h01, 8'ha5);
    rc(ba + 8'h01, 8'ha5, "mask write");
    w(ba + 8'h01, 8'h00);
    w(ba + 8'h08, 8'h40);
    rc(ba + 8'h08, 8'h40, "vector 0");
    raise(0);
    host_model_inst.ack(v, vec);
    check("ack valid", {7'h00, v}, 8'h01);
    check("ack vector", vec, 8'h40);
    rc(ba, 8'h01, "in service after ack");
    w(ba, 8'h20);
    $display("test ack done");
    raise(7);
    raise(1);
    w(ba, 8'h0c);
    rc(ba, 8'h81, "poll lvl 1");
    w(ba, 8'h20);
    w(ba, 8'h0c);
    rc(ba, 8'h87, "poll lvl 7");
    w(ba, 8'h20);
    w(ba, 8'hc3);
    raise(1);
    raise(7);
    w(ba, 8'h0c);
    rc(ba, 8'h87, "set priority");
    w(ba, 8'he7);
    w(ba, 8'h0c);
    rc(ba, 8'h81, "rotate specific");
    w(ba, 8'ha0);
    w(ba, 8'h80);
    w(ba, 8'h00);
    raise(3);
    w(ba, 8'h0f);
    rc(ba, 8'h83, "poll over read");
    rc(ba, 8'h08, "in service after poll");
    w(ba, 8'h63);
    rc(ba, 8'h00, "specific eoi");
    $display("test priority done");
    host_model_inst.init(bb, 8'h13, 8'h02);
    w(bb + 8'h01, 8'h3c);
    rc(bb + 8'h01, 8'h3c, "mask B");
    w(ba, 8'h0a);
    rc(ba, 8'h04, "compat from B");
    host_model_inst.clear_compat();
    raise(8);
    w(bb, 8'h0c);
    rc(bb, 8'h80, "poll B");
    w(bb, 8'h0b);
    rc(bb, 8'h00, "auto eoi");
    $display("test bank B done");
    @(posedge clk);
    irq_n[16] <= 1'h0;
    repeat (6) @(posedge clk);
    host_model_inst.init(bc, 8'h12, 8'h00);
    w(bc + 8'h01, 8'hf0);
    rc(bc + 8'h01, 8'hf0, "mask C");
    rc(bc, 8'h00, "held pin");
    raise(16);
    rc(bc, 8'h01, "new edge");
    w(bc, 8'h0c);
    rc(bc, 8'h80, "poll C");
    w(bc, 8'h0b);
    rc(bc, 8'h01, "no auto eoi");
    $display("test bank C done");
    w(ba, 8'h0b);
    w(ba + 8'h01, 8'hff);
    host_model_inst.init(ba, 8'h1b, 8'h00);
    repeat (6) @(posedge clk);
    rc(ba + 8'h01, 8'h00, "mask reinit");
    rc(ba, 8'h8f, "level pending");
    host_model_inst.clear_compat();
    rc(ba, 8'h8b, "level no compat");
    w(ba, 8'h0c);
    rc(ba, 8'h80, "poll lvl 0");
    w(ba, 8'h0c);
    rc(ba, 8'h00, "nested block");
    w(ba, 8'h68);
    w(ba, 8'h0c);
    rc(ba, 8'h81, "special mask");
    w(ba, 8'h08);
    w(ba, 8'h0c);
    rc(ba, 8'h83, "enable off");
    w(ba, 8'h48);
    w(ba, 8'h0c);
    rc(ba, 8'h00, "normal mask");
    $display("test reinit done");
    conclude();
  end
endmodule : testbench

`default_nettype wire
